// *** common/led_consts.svh ***
`ifndef LED_CONSTS_SVH
`define LED_CONSTS_SVH
`define ADDR_W       4
`define DATA_W       16
`define REG_MODE     4'h0
`define REG_USER     4'h1
`define REG_STATUS   4'h2
`define MODE_LSB     0
`define NSEL_LSB     8
`define UEN_LSB      0
`define ULVL_LSB     8
`define ST_PIN_LSB   0
`define ST_ADDR_LSB  8
`define ST_DONE_BIT  15
`define MODE_RST     8'h00
`define NSEL_RST     2'h0
`define BLINK_MS     100
`define POR_US       10
`define CLK_MHZ      250
`define CNT_W        26
`define NUM_PINS     6
`define NUM_PROG     4
`define STRAP_W      5
`endif

// *** common/led_pkg.sv ***
`default_nettype none
`include "led_consts.svh"
package led_pkg;
  typedef enum logic [1:0] {
    LED_NORMAL = 2'h0,
    LED_ON     = 2'h1,
    LED_OFF    = 2'h2,
    LED_BLINK  = 2'h3
  } led_mode_t;

  typedef enum logic [1:0] {
    ST_POR = 2'h1,
    ST_RUN = 2'h2
  } phase_t;

  typedef struct packed {
    logic link;
    logic activity;
    logic collision;
    logic full_duplex;
    logic speed100;
  } link_status_t;

  typedef struct packed {
    phase_t                      phase;
    logic [`CNT_W-1:0]           por_cnt;
    logic [`CNT_W-1:0]           blink_cnt;
    logic                        blink_lit;
    led_mode_t [`NUM_PROG-1:0]   mode;
    logic [1:0]                  nsel;
    logic [`NUM_PINS-1:0]        user_en;
    logic [`NUM_PINS-1:0]        user_lvl;
    logic [`STRAP_W-1:0]         strap;
    logic [`DATA_W-1:0]          rdata;
    logic [`NUM_PINS-1:0]        pin_out;
    logic [`NUM_PINS-1:0]        pin_oe_n;
    logic                        irq_oe_n;
  } led_state_t;
endpackage
`default_nettype wire

// *** core/led_driver.sv ***
// The register addresses and the strobed register port were decided locally.
`default_nettype none
`include "led_consts.svh"
module led_driver
  import led_pkg::*;
#(
  parameter int BLINK_CYCLES = `BLINK_MS * 1000 * `CLK_MHZ,
  parameter int POR_CYCLES   = `POR_US * `CLK_MHZ,
  // Entry set*4+pin, 3 bits each, selects the event shown: 0 link, 1 activity, 2 collision, 3 full duplex, 4 speed.
  parameter logic [47:0] EVENT_MAP = {3'h1, 3'h0, 3'h2, 3'h2, 3'h4, 3'h2, 3'h0, 3'h1,
                                      3'h3, 3'h2, 3'h1, 3'h0, 3'h1, 3'h0, 3'h3, 3'h4}
)(
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 srst,
  // Register port
  input  wire logic [`ADDR_W-1:0]   reg_addr,
  input  wire logic [`DATA_W-1:0]   reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [`DATA_W-1:0]        reg_rdata,
  // Link status from the transceiver
  input  wire link_status_t         status,
  input  wire logic                 irq_req,
  // Indicator pins
  input  wire logic [`NUM_PINS-1:0] indicator_in,
  output logic [`NUM_PINS-1:0]      indicator_out,
  output logic [`NUM_PINS-1:0]      indicator_oe_n,
  // Interrupt pin, shared with the top strap bit
  input  wire logic                 mgmt_irq_in,
  output logic                      mgmt_irq_out,
  output logic                      mgmt_irq_oe_n,
  // Latched management address
  output logic [`STRAP_W-1:0]       strap_addr_in
);

  localparam logic [2*`NUM_PROG-1:0] MODE_RESET = `MODE_RST;

  led_state_t st;
  led_state_t next_st;
  logic [7:0] events;
  logic [`NUM_PINS-1:0] lit;
  logic [`NUM_PINS-1:0] drive;

  assign events = {3'h0, status.speed100, status.full_duplex, status.collision, status.activity, status.link};

  always_comb
  begin
    next_st = st;
    next_st.rdata = '0;
    lit = '0;
    drive = '0;
    // The blink timer never stops, so every blinking pin stays in phase.
    if (st.blink_cnt == `CNT_W'(BLINK_CYCLES - 1))
    begin
      next_st.blink_cnt = '0;
      next_st.blink_lit = ~st.blink_lit;
    end
    else
    begin
      next_st.blink_cnt = st.blink_cnt + `CNT_W'(1);
    end
    case (st.phase)
      ST_POR:
      begin
        if (st.por_cnt == `CNT_W'(POR_CYCLES - 1))
        begin
          next_st.phase = ST_RUN;
          next_st.strap = ~{mgmt_irq_in, indicator_in[3:0]};
        end
        else
        begin
          next_st.por_cnt = st.por_cnt + `CNT_W'(1);
        end
      end
      ST_RUN:
      begin
        next_st.phase = ST_RUN;
      end
      default:
      begin
        next_st.phase = ST_POR;
      end
    endcase
    if (reg_wr && reg_addr == `REG_MODE)
    begin
      for (int p = 0; p < `NUM_PROG; p++)
      begin
        next_st.mode[p] = led_mode_t'(reg_wdata[`MODE_LSB + 2*p +: 2]);
      end
      next_st.nsel = reg_wdata[`NSEL_LSB +: 2];
    end
    if (reg_wr && reg_addr == `REG_USER)
    begin
      next_st.user_en  = reg_wdata[`UEN_LSB +: `NUM_PINS];
      next_st.user_lvl = reg_wdata[`ULVL_LSB +: `NUM_PINS];
    end
    if (reg_rd)
    begin
      case (reg_addr)
        `REG_MODE:   next_st.rdata = {6'h00, st.nsel, st.mode};
        `REG_USER:   next_st.rdata = {2'h0, st.user_lvl, 2'h0, st.user_en};
        `REG_STATUS: next_st.rdata = {st.phase == ST_RUN, 2'h0, st.strap, 2'h0, st.pin_out ^ st.pin_oe_n};
        default:     next_st.rdata = '0;
      endcase
    end
    // Pins follow the values written in this very cycle, not the old ones.
    for (int p = 0; p < `NUM_PROG; p++)
    begin
      case (next_st.mode[p])
        LED_NORMAL: lit[p] = events[EVENT_MAP[3*(4*next_st.nsel + p) +: 3]];
        LED_ON:     lit[p] = 1'b1;
        LED_OFF:    lit[p] = 1'b0;
        LED_BLINK:  lit[p] = next_st.blink_lit;
        default:    lit[p] = 1'b0;
      endcase
    end
    // A lit LED sinks current, so the pin level is the inverse of lit.
    drive = ~lit;
    for (int p = 0; p < `NUM_PINS; p++)
    begin
      if (next_st.user_en[p])
      begin
        drive[p] = next_st.user_lvl[p];
      end
    end
    if (next_st.phase != ST_RUN)
    begin
      next_st.pin_out  = '0;
      next_st.pin_oe_n = '1;
      next_st.irq_oe_n = 1'b1;
    end
    else
    begin
      // Pins 0 and 1 push both ways; with nsel 0 they show speed and duplex on two LEDs.
      next_st.pin_out[1:0]  = drive[1:0];
      next_st.pin_oe_n[1:0] = 2'h0;
      // Upper pins only sink; the pullup supplies the high level.
      next_st.pin_out[`NUM_PINS-1:2]  = '0;
      next_st.pin_oe_n[`NUM_PINS-1:2] = drive[`NUM_PINS-1:2];
      next_st.irq_oe_n = ~irq_req;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      st           <= '0;
      st.phase     <= ST_POR;
      for (int p = 0; p < `NUM_PROG; p++)
      begin
        st.mode[p] <= led_mode_t'(MODE_RESET[2*p +: 2]);
      end
      st.nsel      <= `NSEL_RST;
      st.pin_oe_n  <= '1;
      st.irq_oe_n  <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign reg_rdata      = st.rdata;
  assign indicator_out  = st.pin_out;
  assign indicator_oe_n = st.pin_oe_n;
  assign mgmt_irq_out   = 1'b0;
  assign mgmt_irq_oe_n  = st.irq_oe_n;
  assign strap_addr_in  = st.strap;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  logic [`NUM_PINS-1:0] pin_level;
  assign pin_level = st.pin_out | st.pin_oe_n;

  chk_force_on: assert property ((st.phase == ST_RUN) && !st.user_en[2] && st.mode[2] == LED_ON
    |-> !st.pin_oe_n[2] && !st.pin_out[2]) else $error("forced-on pin not pulled low");
  chk_force_off: assert property ((st.phase == ST_RUN) && !st.user_en[3] && st.mode[3] == LED_OFF
    |-> st.pin_oe_n[3]) else $error("forced-off pin still driven");
  chk_blink_period: assert property ($changed(st.blink_lit)
    |-> $past(st.blink_cnt) == `CNT_W'(BLINK_CYCLES - 1)) else $error("blink toggled off period");
  chk_user_level: assert property (reg_wr && reg_addr == `REG_USER && reg_wdata[`UEN_LSB] && st.phase == ST_RUN
    |=> st.pin_out[0] == $past(reg_wdata[`ULVL_LSB])) else $error("user level not on pin 0");
  chk_sink_only: assert property (st.pin_out[`NUM_PINS-1:2] == '0)
    else $error("open-drain pin driven high");
  chk_por_float: assert property (st.phase == ST_POR |-> &st.pin_oe_n && st.irq_oe_n)
    else $error("pin driven during power-on reset");
  chk_strap_invert: assert property (st.phase == ST_POR ##1 st.phase == ST_RUN
    |-> st.strap == ~$past({mgmt_irq_in, indicator_in[3:0]})) else $error("strap not latched inverted");
  chk_mode_write: assert property (reg_wr && reg_addr == `REG_MODE
    |=> st.mode == $past(reg_wdata[7:0])) else $error("mode write lost");
  chk_speed_pin: assert property (st.phase == ST_RUN && st.nsel == 2'h0 && st.mode[0] == LED_NORMAL
    && !st.user_en[0] && EVENT_MAP[2:0] == 3'h4 |-> pin_level[0] == !$past(status.speed100))
    else $error("speed pin wrong level");
  chk_duplex_pin: assert property (st.phase == ST_RUN && st.nsel == 2'h0 && st.mode[1] == LED_NORMAL
    && !st.user_en[1] && EVENT_MAP[5:3] == 3'h3 |-> pin_level[1] == !$past(status.full_duplex))
    else $error("duplex pin wrong level");

endmodule // led_driver
`default_nettype wire

// *** test/led_pins.sv ***
`default_nettype none
module led_pins
  import led_pkg::*;
(
  // Design side
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oe_n,
  input  wire logic       irq_out,
  input  wire logic       irq_oe_n,
  // Board straps, present only while strap_on is high
  input  wire logic       strap_on,
  input  wire logic [4:0] strap,
  // Wire levels
  output logic [5:0]      pin_lvl,
  output logic            irq_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] rest_lvl;
  // A released pin rises on its pullup unless the strap network holds it.
  always_comb
  begin
    rest_lvl = strap_on ? {2'h3, strap[3:0]} : 6'h3f;
    for (int i = 0; i < 6; i++)
      pin_lvl[i] = !pin_oe_n[i] ? pin_out[i] : rest_lvl[i];
    irq_lvl = !irq_oe_n ? irq_out : strap_on ? strap[4] : 1'b1;
  end
endmodule // led_pins
`default_nettype wire

// *** test/programmable_led_driver_tb.sv ***
`default_nettype none
module programmable_led_driver_tb
  import led_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         core_clk = 1'b0;
  logic         srst = 1'b1;
  logic [3:0]   reg_addr = 4'h0;
  logic [15:0]  reg_wdata = 16'h0000;
  logic         reg_wr = 1'b0;
  logic         reg_rd = 1'b0;
  logic [15:0]  reg_rdata;
  link_status_t status = '0;
  logic         irq_req = 1'b0;
  logic         strap_on = 1'b1;
  logic [5:0]   indicator_in, indicator_out, indicator_oe_n;
  logic         mgmt_irq_in, mgmt_irq_out, mgmt_irq_oe_n;
  logic [4:0]   strap_addr_in;
  int           err_total = 0;
  int           samples_checked = 0;
  int           cycles = 0;

  led_driver #(.BLINK_CYCLES(8), .POR_CYCLES(4)) i_led_driver (
    .core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .status, .irq_req,
    .indicator_in, .indicator_out, .indicator_oe_n, .mgmt_irq_in, .mgmt_irq_out, .mgmt_irq_oe_n,
    .strap_addr_in);
  led_pins i_led_pins (.pin_out(indicator_out), .pin_oe_n(indicator_oe_n), .irq_out(mgmt_irq_out),
    .irq_oe_n(mgmt_irq_oe_n), .strap_on, .strap(5'h16), .pin_lvl(indicator_in), .irq_lvl(mgmt_irq_in));

  initial
  begin
    forever #2 core_clk = ~core_clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic set_status(input logic [4:0] s);
    @(posedge core_clk);
    status <= link_status_t'(s);
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  task automatic t_por();
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk({mgmt_irq_oe_n, indicator_oe_n}, 16'h007f);
    repeat (6) @(posedge core_clk);
    strap_on <= 1'b0;
    #1;
    chk(strap_addr_in, 16'h0009);
  endtask

  task automatic t_force();
    wr(4'h0, {8'h00, {4{LED_ON}}});
    chk(indicator_in[3:0], 16'h0000);
    wr(4'h0, {8'h00, {4{LED_OFF}}});
    chk(indicator_in[3:0], 16'h000f);
    chk(indicator_oe_n[3:2], 16'h0003);
    rd(4'h0, 16'h00aa);
    rd(4'h3, 16'h0000);
    rd(4'h2, 16'h893f);
  endtask

  task automatic t_blink();
    logic [15:0] lows;
    logic [15:0] flips;
    logic        prev;
    lows  = 16'h0000;
    flips = 16'h0000;
    wr(4'h0, {8'h00, LED_OFF, LED_BLINK, LED_OFF, LED_OFF});
    prev = indicator_in[2];
    repeat (32)
    begin
      @(posedge core_clk);
      #1;
      lows  += {15'h0000, ~indicator_in[2]};
      flips += {15'h0000, indicator_in[2] ^ prev};
      prev  = indicator_in[2];
    end
    chk(lows, 16'h0010);
    chk(flips, 16'h0004);
  endtask

  task automatic t_normal();
    wr(4'h0, 16'h0000);
    set_status(5'h01);
    chk(indicator_in[3:0], 16'h000e);
    chk(indicator_oe_n[1:0], 16'h0000);
    set_status(5'h1e);
    chk(indicator_in[3:0], 16'h0001);
    wr(4'h0, 16'h0100);
    chk(indicator_in[3:0], 16'h0000);
  endtask

  task automatic t_user();
    wr(4'h1, 16'h2a3f);
    chk(indicator_in, 16'h002a);
    @(posedge core_clk);
    irq_req <= 1'b1;
    @(posedge core_clk);
    #1;
    chk({mgmt_irq_out, mgmt_irq_oe_n, mgmt_irq_in}, 16'h0000);
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // The whole sequence needs under a hundred cycles; the ceiling leaves ample slack.
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      err_total++;
      report_and_stop();
    end
  end

  initial
  begin
    t_por();
    t_force();
    t_blink();
    t_normal();
    t_user();
    report_and_stop();
  end
endmodule // programmable_led_driver_tb
`default_nettype wire
